// >>> hw/cfa_params.svh
// Summary of operation
// RULE_01 - multiply/divide: overflow when result exceeds a word, always on divide by zero
// RULE_02 - logical operations always clear overflow
// RULE_03 - shift/rotate right: overflow is sticky OR of bits lost before the last
// RULE_04 - one-operand bit ops clear overflow; two-operand ops load OR of bits
// RULE_05 - ordinary operations: zero flag set exactly when result is zero
// RULE_06 - add/subtract with carry: zero only if already zero and result zero
// RULE_07 - bit ops: zero is inverted old bit or NOR; prioritize flags zero operand
// RULE_08 - table end cleared for unsuited ops, else set on most negative source
// RULE_09 - interrupt entry sets interrupted-muldiv flag when muldiv was cut short
// RULE_10 - after service the flag decides whether muldiv resumes
// RULE_11 - interrupt return overwrites the flag with the stacked value
// RULE_12 - interrupts accepted only while global enable is one
// RULE_13 - four-bit priority level, set on interrupt entry and writable by software
// RULE_14 - at level fifteen only traps and non-maskable interrupts get through
// RULE_15 - reset clears global enable and sets priority level to zero
// RULE_16 - hidden 16-bit offset moves on branch, fetch, and stack return only; code also loads the vector on interrupt entry and trap
// RULE_17 - low eight bits of segment register are the segment number
// RULE_18 - segmented: segment above offset; unsegmented: offset alone
// RULE_19 - segmented: selected count of segment bits driven on segment pins
// RULE_20 - unsegmented or single-chip: fetches restricted to segment zero
// RULE_21 - segment register changes only by segment jump/call or stack returns; code also zeroes it on interrupt entry and trap
// RULE_22 - segment register forced to zero on interrupt accept or software trap
// RULE_23 - reset clears all status flags
// RULE_24 - reset selects segmented mode
`ifndef CFA_PARAMS_SVH
`define CFA_PARAMS_SVH
`define CFA_OFS_CSEG 4'h0
`define CFA_OFS_PSW 4'h4
`define CFA_OFS_CFG 4'h8
`define CFA_PSW_V 0
`define CFA_PSW_Z 1
`define CFA_PSW_E 2
`define CFA_PSW_MULDIV_INTERRUPTED_FLAG 3
`define CFA_PSW_IEN 4
`define CFA_PSW_LVL 8
`define CFA_CFG_SGTOFF 0
`define CFA_CFG_SEGBITS 4
`define CFA_SEGBITS_RST 4'h2
`define CFA_SEGBITS_MAX 4'h8
`define CFA_LVL_TOP 4'hf
`define CFA_MINW 16'h8000
`define CFA_MINB 8'h80
`define CFA_RESP_OK 2'h0
`define CFA_RESP_ERR 2'h2
`endif

// >>> hw/cfa_pkg.sv
package cfa_pkg;
	typedef enum logic [3:0] {
		CFA_OP_NONE,
		CFA_OP_ARITH,
		CFA_OP_ADDC,
		CFA_OP_MULDIV,
		CFA_OP_LOGIC,
		CFA_OP_SHR,
		CFA_OP_SHL,
		CFA_OP_BIT1,
		CFA_OP_BIT2,
		CFA_OP_PRIOR,
		CFA_OP_MOVE
	} cfa_op_t;
	// one finished ALU or move operation
	typedef struct packed {
		logic        valid;
		cfa_op_t     cls;
		logic        isByte;
		logic [15:0] result;
		logic [15:0] srcOp;
		logic [15:0] secondOp;
		logic        bitA;
		logic        bitB;
		logic        arithOvf;
		logic        noFit;
		logic        divZero;
		logic        lostBits;
		logic        tableOk;
	} cfa_alu_t;
	// program flow events
	typedef struct packed {
		logic        irqEntry;
		logic        mulCut;
		logic [3:0]  irqLevel;
		logic [15:0] vector;
		logic        trapOp;
		logic        segJump;
		logic        segCall;
		logic        segRet;
		logic        intRet;
		logic        branch;
		logic        fetch;
		logic [2:0]  fetchLen;
		logic [15:0] ipTarget;
		logic [15:0] segTarget;
		logic [15:0] popSeg;
		logic [15:0] popIp;
		logic        popMulip;
		logic        popIen;
		logic [3:0]  popLevel;
	} cfa_flow_t;
	// request arriving at the acceptance check
	typedef struct packed {
		logic       valid;
		logic [3:0] level;
		logic       nmi;
		logic       trap;
	} cfa_irq_t;
endpackage : cfa_pkg

// >>> hw/cfa_core.sv
`timescale 1ns/1ns
`include "cfa_params.svh"
module cfa_core
	import cfa_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	// pipeline side
	input  wire cfa_alu_t    aluIn,
	input  wire cfa_flow_t   flowIn,
	input  wire cfa_irq_t    irqIn,
	input  wire logic        singleChip,
	// status and fetch path
	output logic             ovfFlag,
	output logic             zeroFlag,
	output logic             tableEnd,
	output logic             mulipFlag,
	output logic             gie,
	output logic [3:0]       prioLevel,
	output logic             irqTake,
	output logic             mulResume,
	output logic [15:0]      instrOffset,
	output logic [23:0]      codeAddr,
	output logic [7:0]       segPins,
	// AXI4-Lite slave
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// zero test at operand width
	function automatic logic isZero(input logic [15:0] v, input logic b);
		isZero = b ? (v[7:0] == 8'h00) : (v == 16'h0000);
	endfunction : isZero

	// most negative value at operand width
	function automatic logic isMinNeg(input logic [15:0] v, input logic b);
		isMinNeg = b ? (v[7:0] == `CFA_MINB) : (v == `CFA_MINW);
	endfunction : isMinNeg

	// mask of segment bits driven on the pins
	function automatic logic [7:0] segMask(input logic [3:0] n);
		logic [3:0] c;
		c = (n > `CFA_SEGBITS_MAX) ? `CFA_SEGBITS_MAX : n;
		segMask = 8'hff >> (4'h8 - c); // a zero count shifts every bit out
	endfunction : segMask

	// reset release through two flops
	logic [1:0] rstPipe;
	logic       rstN;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rstPipe <= 2'b00;
		else
			rstPipe <= {rstPipe[0], 1'b1};
	end
	assign rstN = rstPipe[1];

	// single-chip strap from a pin, two flops before use
	logic chipMeta;
	logic chipSync;
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			chipMeta <= 1'b0;
			chipSync <= 1'b0;
		end
		else if (clkEn)
		begin
			chipMeta <= singleChip;
			chipSync <= chipMeta;
		end
	end

	// register bus state
	logic        awHeld;
	logic [3:0]  awAddr;
	logic        wHeld;
	logic [31:0] wData;
	logic [3:0]  wStrb;
	logic        next_awHeld;
	logic [3:0]  next_awAddr;
	logic        next_wHeld;
	logic [31:0] next_wData;
	logic [3:0]  next_wStrb;
	logic        next_awready;
	logic        next_wready;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_arready;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic        wrCommit;
	logic        swPsw;
	logic        swCfg;

	// core state
	logic [15:0] cseg;
	logic        segOff;
	logic [3:0]  segBits;
	logic        next_ovf;
	logic        next_zero;
	logic        next_tEnd;
	logic        next_muldiv_interrupted_flag;
	logic        next_gie;
	logic [3:0]  next_level;
	logic        next_take;
	logic        next_resume;
	logic [15:0] next_ip;
	logic [15:0] next_cseg;
	logic        next_segOff;
	logic [3:0]  next_segBits;
	logic [23:0] next_addr;
	logic [7:0]  next_pins;
	logic [15:0] pswView;
	logic        unseg;

	// software view of the status word
	always_comb
	begin
		pswView = 16'h0000;
		pswView[`CFA_PSW_V] = ovfFlag;
		pswView[`CFA_PSW_Z] = zeroFlag;
		pswView[`CFA_PSW_E] = tableEnd;
		pswView[`CFA_PSW_MULDIV_INTERRUPTED_FLAG] = mulipFlag;
		pswView[`CFA_PSW_IEN] = gie;
		pswView[`CFA_PSW_LVL +: 4] = prioLevel;
	end

	// write channel: address and data taken in either order, committed once both held
	always_comb
	begin
		next_awHeld = awHeld;
		next_awAddr = awAddr;
		next_wHeld = wHeld;
		next_wData = wData;
		next_wStrb = wStrb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		wrCommit = awHeld && wHeld && !s_axi_bvalid;
		swPsw = wrCommit && (awAddr == `CFA_OFS_PSW);
		swCfg = wrCommit && (awAddr == `CFA_OFS_CFG);
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (wrCommit)
		begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			// segment register is read-only to data writes
			next_bresp = (swPsw || swCfg) ? `CFA_RESP_OK : `CFA_RESP_ERR; // RULE_21
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		next_awready = !next_awHeld;
		next_wready = !next_wHeld;
	end

	// read channel: one cycle from address to data
	always_comb
	begin
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = `CFA_RESP_OK;
			unique case (s_axi_araddr)
				`CFA_OFS_CSEG: next_rdata = {16'h0000, cseg};
				`CFA_OFS_PSW: next_rdata = {16'h0000, pswView};
				`CFA_OFS_CFG: next_rdata = {24'h00_0000, segBits, 3'h0, segOff};
				default:
				begin
					next_rdata = 32'h0000_0000;
					next_rresp = `CFA_RESP_ERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			awHeld <= 1'b0;
			awAddr <= 4'h0;
			wHeld <= 1'b0;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end
		else if (clkEn)
		begin
			awHeld <= next_awHeld;
			awAddr <= next_awAddr;
			wHeld <= next_wHeld;
			wData <= next_wData;
			wStrb <= next_wStrb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready || (!s_axi_arready && !s_axi_rvalid);
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// condition flags; a software write replaces what the pipeline produced
	always_comb
	begin
		next_ovf = ovfFlag;
		next_zero = zeroFlag;
		next_tEnd = tableEnd;
		if (aluIn.valid)
		begin
			next_zero = isZero(aluIn.result, aluIn.isByte); // RULE_05
			next_tEnd = aluIn.tableOk && isMinNeg(aluIn.srcOp, aluIn.isByte); // RULE_08
			unique case (aluIn.cls)
				CFA_OP_ARITH: next_ovf = aluIn.arithOvf;
				CFA_OP_ADDC:
				begin
					next_ovf = aluIn.arithOvf;
					next_zero = zeroFlag && isZero(aluIn.result, aluIn.isByte); // RULE_06
				end
				CFA_OP_MULDIV: next_ovf = aluIn.noFit || aluIn.divZero; // RULE_01
				CFA_OP_LOGIC: next_ovf = 1'b0; // RULE_02
				CFA_OP_SHR: next_ovf = aluIn.lostBits; // RULE_03
				CFA_OP_BIT1:
				begin
					next_ovf = 1'b0; // RULE_04
					next_zero = !aluIn.bitA; // RULE_07
				end
				CFA_OP_BIT2:
				begin
					next_ovf = aluIn.bitA || aluIn.bitB; // RULE_04
					next_zero = !(aluIn.bitA || aluIn.bitB); // RULE_07
				end
				CFA_OP_PRIOR: next_zero = isZero(aluIn.secondOp, 1'b0); // RULE_07
				CFA_OP_SHL, CFA_OP_MOVE: next_ovf = ovfFlag;
				default:
				begin
					next_zero = zeroFlag;
					next_tEnd = tableEnd;
				end
			endcase
		end
		if (swPsw && wStrb[0])
		begin
			next_ovf = wData[`CFA_PSW_V];
			next_zero = wData[`CFA_PSW_Z];
			next_tEnd = wData[`CFA_PSW_E];
		end
	end

	// interrupt status; return wins over software writes, entry only over the level write
	always_comb
	begin
		next_muldiv_interrupted_flag = mulipFlag;
		next_gie = gie;
		next_level = prioLevel;
		next_resume = 1'b0;
		if (swPsw && wStrb[0])
		begin
			next_muldiv_interrupted_flag = wData[`CFA_PSW_MULDIV_INTERRUPTED_FLAG];
			next_gie = wData[`CFA_PSW_IEN];
		end
		if (swPsw && wStrb[1])
			next_level = wData[`CFA_PSW_LVL +: 4]; // RULE_13
		if (flowIn.intRet)
		begin
			next_muldiv_interrupted_flag = flowIn.popMulip; // RULE_11
			next_resume = flowIn.popMulip; // RULE_10
			next_gie = flowIn.popIen;
			next_level = flowIn.popLevel;
		end
		if (flowIn.irqEntry)
		begin
			next_muldiv_interrupted_flag = flowIn.mulCut || (swPsw ? next_muldiv_interrupted_flag : mulipFlag); // RULE_09
			next_level = flowIn.irqLevel; // RULE_13
		end
		// acceptance: enable gate, priority compare, top level lets only traps and nmi in
		next_take = irqIn.trap || irqIn.nmi; // RULE_14
		if (irqIn.valid && gie && prioLevel != `CFA_LVL_TOP) // RULE_12 RULE_14
			next_take = next_take || (irqIn.level > prioLevel);
	end

	// flags and interrupt status, all cleared on reset
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			ovfFlag <= 1'b0; // RULE_23
			zeroFlag <= 1'b0; // RULE_23
			tableEnd <= 1'b0; // RULE_23
			mulipFlag <= 1'b0; // RULE_23
			gie <= 1'b0; // RULE_15
			prioLevel <= 4'h0; // RULE_15
			irqTake <= 1'b0;
			mulResume <= 1'b0;
		end
		else if (clkEn)
		begin
			ovfFlag <= next_ovf;
			zeroFlag <= next_zero;
			tableEnd <= next_tEnd;
			mulipFlag <= next_muldiv_interrupted_flag;
			gie <= next_gie;
			prioLevel <= next_level;
			irqTake <= next_take;
			mulResume <= next_resume;
		end
	end

	// code addressing: offset, segment register and mode
	always_comb
	begin
		next_ip = instrOffset;
		next_cseg = cseg;
		next_segOff = segOff;
		next_segBits = segBits;
		if (swCfg && wStrb[0])
		begin
			next_segOff = wData[`CFA_CFG_SGTOFF];
			next_segBits = wData[`CFA_CFG_SEGBITS +: 4];
		end
		// offset moves by fetch, branch, stack return, or to the vector on interrupt entry or trap
		if (flowIn.fetch)
			next_ip = instrOffset + {13'h0000, flowIn.fetchLen}; // RULE_16
		if (flowIn.branch || flowIn.segJump || flowIn.segCall)
			next_ip = flowIn.ipTarget; // RULE_16
		if (flowIn.segRet || flowIn.intRet)
			next_ip = flowIn.popIp; // RULE_16
		if (flowIn.irqEntry || flowIn.trapOp)
			next_ip = flowIn.vector;
		if (flowIn.segJump || flowIn.segCall)
			next_cseg = flowIn.segTarget; // RULE_21
		// unsegmented returns never pop a segment
		if ((flowIn.segRet || flowIn.intRet) && !segOff)
			next_cseg = flowIn.popSeg; // RULE_21
		if (flowIn.irqEntry || flowIn.trapOp)
			next_cseg = 16'h0000; // RULE_22
		unseg = next_segOff || chipSync;
		// the address is built from the updated offset so it tracks the next fetch
		next_addr = {unseg ? 8'h00 : next_cseg[7:0], next_ip}; // RULE_17 RULE_18 RULE_20
		next_pins = unseg ? 8'h00 : (next_cseg[7:0] & segMask(next_segBits)); // RULE_19
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			instrOffset <= 16'h0000;
			cseg <= 16'h0000;
			segOff <= 1'b0; // RULE_24
			segBits <= `CFA_SEGBITS_RST;
			codeAddr <= 24'h00_0000;
			segPins <= 8'h00;
		end
		else if (clkEn)
		begin
			instrOffset <= next_ip;
			cseg <= next_cseg;
			segOff <= next_segOff;
			segBits <= next_segBits;
			codeAddr <= next_addr;
			segPins <= next_pins;
		end
	end

endmodule : cfa_core

// >>> tb/cfa_core_properties.sv
`timescale 1ns/1ns
`include "cfa_params.svh"
module cfa_core_properties
	import cfa_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        clkEn,
	// pipeline side
	input wire cfa_alu_t    aluIn,
	input wire cfa_flow_t   flowIn,
	input wire cfa_irq_t    irqIn,
	// status and fetch path
	input wire logic        ovfFlag,
	input wire logic        zeroFlag,
	input wire logic        tableEnd,
	input wire logic        gie,
	input wire logic [3:0]  prioLevel,
	input wire logic        irqTake,
	input wire logic        mulResume,
	input wire logic [15:0] instrOffset,
	input wire logic [23:0] codeAddr,
	input wire logic [7:0]  segPins,
	// bus write side
	input wire logic [3:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// a bus commit may override flags, so ops count only while the write path idles
	logic aluGo;
	logic resZero;
	logic srcMin;
	assign aluGo   = aluIn.valid && clkEn && s_axi_awready;
	assign resZero = aluIn.isByte ? (aluIn.result[7:0] == 8'h00) : (aluIn.result == 16'h0000);
	assign srcMin  = aluIn.isByte ? (aluIn.srcOp[7:0] == `CFA_MINB) : (aluIn.srcOp == `CFA_MINW);

	// event steps
	sequence s_entry;
		flowIn.irqEntry && clkEn;
	endsequence
	sequence s_resume;
		flowIn.intRet && flowIn.popMulip && !flowIn.irqEntry && !flowIn.trapOp && clkEn;
	endsequence
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	a_muldiv_ovf: assert property (
		aluGo && aluIn.cls == CFA_OP_MULDIV |=> ovfFlag == ($past(aluIn.noFit) || $past(aluIn.divZero)))
		else $error("overflow wrong after multiply or divide");
	a_logic_ovf: assert property (
		aluGo && aluIn.cls == CFA_OP_LOGIC |=> !ovfFlag)
		else $error("overflow left set by logical op");
	a_shift_sticky: assert property (
		aluGo && aluIn.cls == CFA_OP_SHR |=> ovfFlag == $past(aluIn.lostBits))
		else $error("sticky bit wrong after shift right");
	a_bit_pair: assert property (
		aluGo && aluIn.cls == CFA_OP_BIT2 |=> ovfFlag == ($past(aluIn.bitA) || $past(aluIn.bitB))
			&& zeroFlag == !($past(aluIn.bitA) || $past(aluIn.bitB)))
		else $error("two-bit op flags wrong");
	a_carry_zero: assert property (
		aluGo && aluIn.cls == CFA_OP_ADDC |=> zeroFlag == ($past(zeroFlag) && $past(resZero)))
		else $error("zero chain wrong after carry op");
	a_table_end: assert property (
		aluGo && aluIn.cls != CFA_OP_NONE |=> tableEnd == ($past(aluIn.tableOk) && $past(srcMin)))
		else $error("table end flag wrong");
	a_irq_accept: assert property (
		clkEn |=> irqTake == ($past(irqIn.trap) || $past(irqIn.nmi) || ($past(irqIn.valid)
			&& $past(gie) && $past(prioLevel) != `CFA_LVL_TOP && $past(irqIn.level) > $past(prioLevel))))
		else $error("interrupt acceptance wrong");
	a_entry_state: assert property (
		s_entry |=> prioLevel == $past(flowIn.irqLevel) && instrOffset == $past(flowIn.vector)
			&& codeAddr == {8'h00, $past(flowIn.vector)})
		else $error("state wrong after interrupt entry");
	a_trap_segment: assert property (
		flowIn.trapOp && clkEn |=> codeAddr[23:16] == 8'h00 && segPins == 8'h00)
		else $error("segment not cleared by trap");
	a_resume_pulse: assert property (
		s_resume |=> mulResume)
		else $error("no resume after return with cut op");
	a_write_answer: assert property (
		s_wr_both |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_seg_readonly: assert property (
		s_wr_both ##0 s_axi_awaddr == `CFA_OFS_CSEG |-> ##2 s_axi_bresp == `CFA_RESP_ERR)
		else $error("segment register write not refused");
endmodule : cfa_core_properties

// >>> tb/cfa_core_test.sv
`timescale 1ns/1ns
`include "cfa_params.svh"
module cfa_core_test
	import cfa_pkg::*;
	;
	// design stimulus and observation
	logic        clk;
	logic        rst_n;
	cfa_alu_t    aluIn;
	cfa_flow_t   flowIn;
	cfa_flow_t   ev;
	cfa_irq_t    irqIn;
	logic        singleChip;
	logic        clkEn;
	logic        ovfFlag, zeroFlag, tableEnd, mulipFlag, gie, irqTake, mulResume;
	logic [3:0]  prioLevel;
	logic [15:0] instrOffset;
	logic [23:0] codeAddr;
	logic [7:0]  segPins;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          num_errors;
	int          compares;

	cfa_core i_dut (.clk, .rst_n, .clkEn, .aluIn, .flowIn, .irqIn, .singleChip, .ovfFlag,
		.zeroFlag, .tableEnd, .mulipFlag, .gie, .prioLevel, .irqTake, .mulResume, .instrOffset,
		.codeAddr, .segPins, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);

	// 125 MHz
	always #4 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// both channels offered at once, each dropped when taken; nonblocking drives after the rising edge keep drivers apart
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// no cycle limit here: only the watchdog ends a hung wait
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		check(32'(s_axi_bvalid), 32'h0000_0001);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask : axi_write

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		check(32'({s_axi_rvalid, s_axi_rresp}), 32'({1'b1, er}));
		check(s_axi_rdata, exp);
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask : rd_chk

	// one-cycle op; m = {byte, tableOk, bitA, bitB, overflow-ish, divZero}; e = {mask, E Z V}
	task automatic t_op(input cfa_op_t c, input logic [5:0] m, input logic [15:0] r,
		input logic [15:0] s, input logic [5:0] e);
		aluIn <= {1'b1, c, m[5], r, s, s, m[3], m[2], m[1], m[1], m[0], m[1], m[4]};
		@(posedge clk);
		aluIn <= '0;
		@(posedge clk);
		check(32'({tableEnd, zeroFlag, ovfFlag} & e[5:3]), 32'(e[2:0]));
	endtask : t_op

	task automatic t_flow();
		flowIn <= ev;
		ev = '0;
		@(posedge clk);
		flowIn <= '0;
		@(posedge clk);
	endtask : t_flow

	task automatic t_irq(input logic [6:0] q, input logic e);
		irqIn <= q;
		@(posedge clk);
		irqIn <= '0;
		@(posedge clk);
		check(32'(irqTake), 32'(e));
	endtask : t_irq

	// main sequence
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		{aluIn, flowIn, ev, irqIn, singleChip} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		clkEn = 1'b1;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd_chk(4'h4, 32'h0000_0000, `CFA_RESP_OK);
		rd_chk(4'h8, 32'h0000_0020, `CFA_RESP_OK);
		check(32'(codeAddr), 32'h0000_0000);
		t_op(CFA_OP_MULDIV, 6'h02, 16'h1234, 16'h0000, 6'h39);
		t_op(CFA_OP_MULDIV, 6'h00, 16'h00ff, 16'h0000, 6'h38);
		t_op(CFA_OP_MULDIV, 6'h01, 16'h0001, 16'h0000, 6'h39);
		t_op(CFA_OP_LOGIC, 6'h00, 16'h0000, 16'h0000, 6'h3a);
		t_op(CFA_OP_ARITH, 6'h22, 16'h0100, 16'h0000, 6'h3b);
		t_op(CFA_OP_SHR, 6'h00, 16'h0001, 16'h0000, 6'h38);
		t_op(CFA_OP_SHR, 6'h02, 16'h0000, 16'h0000, 6'h3b);
		t_op(CFA_OP_BIT1, 6'h08, 16'h0000, 16'h0000, 6'h38);
		t_op(CFA_OP_BIT1, 6'h00, 16'h0001, 16'h0000, 6'h3a);
		t_op(CFA_OP_BIT2, 6'h04, 16'h0000, 16'h0000, 6'h39);
		t_op(CFA_OP_BIT2, 6'h00, 16'h0001, 16'h0000, 6'h3a);
		t_op(CFA_OP_PRIOR, 6'h00, 16'h0001, 16'h0000, 6'h32);
		t_op(CFA_OP_PRIOR, 6'h00, 16'h0000, 16'h8000, 6'h30);
		t_op(CFA_OP_ADDC, 6'h00, 16'h0000, 16'h0000, 6'h10);
		t_op(CFA_OP_ARITH, 6'h00, 16'h0000, 16'h0000, 6'h3a);
		t_op(CFA_OP_ADDC, 6'h00, 16'h0000, 16'h0000, 6'h12);
		t_op(CFA_OP_ADDC, 6'h00, 16'h0005, 16'h0000, 6'h10);
		t_op(CFA_OP_ADDC, 6'h00, 16'h0000, 16'h0000, 6'h10);
		t_op(CFA_OP_MOVE, 6'h10, 16'h8000, 16'h8000, 6'h24);
		t_op(CFA_OP_MOVE, 6'h10, 16'h0080, 16'h0080, 6'h20);
		t_op(CFA_OP_MOVE, 6'h30, 16'h0080, 16'h0080, 6'h24);
		t_op(CFA_OP_MOVE, 6'h30, 16'h8000, 16'h8000, 6'h20);
		t_op(CFA_OP_MOVE, 6'h10, 16'h8000, 16'h8000, 6'h24);
		t_op(CFA_OP_MOVE, 6'h00, 16'h8000, 16'h8000, 6'h20);
		// low enable freezes the flags; left shift keeps overflow
		clkEn <= 1'b0;
		t_op(CFA_OP_ARITH, 6'h02, 16'h0000, 16'h8000, 6'h38);
		clkEn <= 1'b1;
		t_op(CFA_OP_SHL, 6'h02, 16'h0000, 16'h0000, 6'h3a);
		// reserved upper byte kept but not used for addressing
		ev.segJump = 1'b1;
		ev.segTarget = 16'hff37;
		ev.ipTarget = 16'h1234;
		t_flow();
		check(32'(codeAddr), 32'h0037_1234);
		check(32'(segPins), 32'h0000_0003);
		axi_write(4'h0, 32'h0000_0001, resp);
		check(32'(resp), 32'(`CFA_RESP_ERR));
		rd_chk(4'h0, 32'h0000_ff37, `CFA_RESP_OK);
		axi_write(4'hc, 32'h0000_0001, resp);
		check(32'(resp), 32'(`CFA_RESP_ERR));
		rd_chk(4'hc, 32'h0000_0000, `CFA_RESP_ERR);
		ev.fetch = 1'b1;
		ev.fetchLen = 3'h4;
		t_flow();
		check(32'(instrOffset), 32'h0000_1238);
		ev.branch = 1'b1;
		ev.ipTarget = 16'h2000;
		t_flow();
		check(32'(codeAddr), 32'h0037_2000);
		// pin count: eight, then past eight clamps, then unsegmented
		axi_write(4'h8, 32'h0000_0080, resp);
		check(32'(segPins), 32'h0000_0037);
		axi_write(4'h8, 32'h0000_00f0, resp);
		check(32'(segPins), 32'h0000_0037);
		axi_write(4'h8, 32'h0000_0041, resp);
		check(32'({segPins, codeAddr}), 32'h0000_2000);
		axi_write(4'h8, 32'h0000_0040, resp);
		check(32'(segPins), 32'h0000_0007);
		// single-chip pin passes two flops before it counts
		singleChip <= 1'b1;
		repeat (4) @(posedge clk);
		check(32'({segPins, codeAddr}), 32'h0000_2000);
		singleChip <= 1'b0;
		repeat (4) @(posedge clk);
		check(32'(codeAddr), 32'h0037_2000);
		ev.irqEntry = 1'b1;
		ev.mulCut = 1'b1;
		ev.irqLevel = 4'h5;
		ev.vector = 16'h0040;
		t_flow();
		check(32'({mulipFlag, prioLevel}), 32'h0000_0015);
		check(32'(codeAddr), 32'h0000_0040);
		ev.intRet = 1'b1;
		ev.popMulip = 1'b1;
		ev.popIen = 1'b1;
		ev.popLevel = 4'h3;
		ev.popSeg = 16'h0042;
		ev.popIp = 16'h0104;
		t_flow();
		check(32'({mulResume, mulipFlag, gie, prioLevel}), 32'h0000_0073);
		check(32'(codeAddr), 32'h0042_0104);
		ev.intRet = 1'b1;
		ev.popIen = 1'b1;
		ev.popLevel = 4'h3;
		t_flow();
		check(32'({mulResume, mulipFlag, gie, prioLevel}), 32'h0000_0013);
		ev.segCall = 1'b1;
		ev.segTarget = 16'h0011;
		t_flow();
		ev.trapOp = 1'b1;
		ev.vector = 16'h0020;
		t_flow();
		check(32'(codeAddr), 32'h0000_0020);
		// acceptance against enable and level; trap and nmi pass level fifteen
		t_irq({1'b1, 4'h4, 2'h0}, 1'b1);
		t_irq({1'b1, 4'h3, 2'h0}, 1'b0);
		axi_write(4'h4, 32'h0000_0f10, resp);
		rd_chk(4'h4, 32'h0000_0f10, `CFA_RESP_OK);
		t_irq({1'b1, 4'hf, 2'h0}, 1'b0);
		t_irq({1'b0, 4'h0, 2'h2}, 1'b1);
		t_irq({1'b0, 4'h0, 2'h1}, 1'b1);
		axi_write(4'h4, 32'h0000_0300, resp);
		t_irq({1'b1, 4'h9, 2'h0}, 1'b0);
		test_done();
	end

	// about 160 cycles of traffic; far beyond that is a hang
	initial
	begin
		#160000;
		num_errors++;
		test_done();
	end
endmodule : cfa_core_test

bind cfa_core cfa_core_properties i_props (.clk, .rst_n, .clkEn, .aluIn, .flowIn, .irqIn,
	.ovfFlag, .zeroFlag, .tableEnd, .gie, .prioLevel, .irqTake, .mulResume, .instrOffset,
	.codeAddr, .segPins, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid);
